// ===== verilog/counter_array_defines.svh
// Behaviour
// - Writing enable or lock bit enables watchdog
// - Lock set blocks disabling until reset
// - Unlocked, writing enable and lock zero disables watchdog
// - Clock select, idle-suspend frozen while enabled
// - Watchdog comes up enabled after reset
// - Reset selects divide-by-12, clears low, offset
// - Defaults give reset after 3072 system clocks
// - Wrap flag set on 0xFFFF to 0x0000
// - Flags cleared only by reset or software writing zero
// - Wrap flag requests interrupt when enabled
// - Five module flags, set by events, interrupt
// - Run bit starts and stops the counter while watchdog disabled
// - Control bit 5 reads zero, ignores writes
// - Control bit-addressable at 0xD8, resets zero
// - Mode register field layout and reset values
// - Low overflow with high match issues reset
// - Update write loads high plus offset
// - Clock select encodings for time base
// - Enabled watchdog freezes other mode bits except lock
`ifndef COUNTER_ARRAY_DEFINES_SVH
`define COUNTER_ARRAY_DEFINES_SVH

// ----------------------------------------
// Special-function addresses
// ----------------------------------------
`define ADDR_CONTROL      8'hD8
`define ADDR_MODE         8'hD9
`define ADDR_COUNT_LOW    8'hF9
`define ADDR_COUNT_HIGH   8'hFA
`define ADDR_WD_OFFSET    8'hFB
`define ADDR_WD_UPDATE    8'hFC
`define BIT_BASE_CONTROL  5'h1B

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTL_WRAP          7
`define CTL_RUN           6
`define CTL_UNUSED        5
`define CTL_FLAG_HI       4
`define CTL_RESET         8'h00

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define MODE_IDLE         7
`define MODE_WD_EN        6
`define MODE_LOCK         5
`define MODE_UNUSED       4
`define MODE_SEL_HI       3
`define MODE_SEL_LO       1
`define MODE_WRAP_IE      0
`define MODE_RESET        8'h40

// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define COUNT_RESET       16'h0000
`define BYTE_RESET        8'h00
`define DIV_SLOW          12
`define DIV_FAST          4
`define DIV_EXT           8
`define WD_DEFAULT_TICKS  256
`define WD_DEFAULT_CYCLES (`WD_DEFAULT_TICKS * `DIV_SLOW)

`endif

// ===== verilog/counter_array_pkg.sv
package counter_array_pkg;

  typedef enum logic [2:0] {
    SEL_DIV12   = 3'b000,
    SEL_DIV4    = 3'b001,
    SEL_TIMER0  = 3'b010,
    SEL_EXT_PIN = 3'b011,
    SEL_SYSTEM_CLOCK  = 3'b100,
    SEL_EXT_DIV = 3'b101
  } clock_select_type;

endpackage

// ===== verilog/sticky_flag.sv
`timescale 1ns/1ps
`default_nettype none

module sticky_flag (
  input  wire logic clk_sys_in,   // System clock
  input  wire logic reset_in,     // Synchronous reset
  input  wire logic hw_set_in,    // Hardware event
  input  wire logic sw_write_in,  // Software write strobe
  input  wire logic sw_value_in,  // Software write value
  output logic      flag_out      // Sticky flag
);

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      flag_out <= 1'b0;
    end else if (hw_set_in) begin
      flag_out <= 1'b1;
    end else if (sw_write_in) begin
      flag_out <= sw_value_in;
    end
  end

endmodule

`default_nettype wire

// ===== verilog/counter_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "counter_array_defines.svh"

module counter_tick_gen (
  input  wire logic       clk_sys_in,     // System clock
  input  wire logic       reset_in,       // Synchronous reset
  input  wire logic [2:0] select_in,      // Time base select
  input  wire logic       timer0_ovf_in,  // Timer 0 overflow pulse
  input  wire logic       ext_pin_in,     // External count pin
  input  wire logic       ext_clk_in,     // External clock
  output logic            tick_out        // One-cycle count tick
);

  logic [3:0] div_count;
  logic [2:0] ext_count;
  logic       ext_pin_q;
  logic       ext_clk_q;
  logic       div_wrap;
  logic       next_tick;

  // Prescaler shared by both divided system-clock choices
  always_comb begin
    if (select_in == counter_array_pkg::SEL_DIV4) begin
      div_wrap = (div_count == 4'(`DIV_FAST - 1));
    end else begin
      div_wrap = (div_count == 4'(`DIV_SLOW - 1));
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in || div_wrap) begin
      div_count <= 4'h0;
    end else begin
      div_count <= div_count + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ext_pin_q <= 1'b0;
      ext_clk_q <= 1'b0;
      ext_count <= 3'h0;
    end else begin
      ext_pin_q <= ext_pin_in;
      ext_clk_q <= ext_clk_in;
      if (ext_clk_in && !ext_clk_q) begin
        ext_count <= ext_count + 3'h1;
      end
    end
  end

  always_comb begin
    case (select_in)
      counter_array_pkg::SEL_DIV12:   next_tick = div_wrap;
      counter_array_pkg::SEL_DIV4:    next_tick = div_wrap;
      counter_array_pkg::SEL_TIMER0:  next_tick = timer0_ovf_in;
      counter_array_pkg::SEL_EXT_PIN: next_tick = ext_pin_q && !ext_pin_in;
      counter_array_pkg::SEL_SYSTEM_CLOCK:  next_tick = 1'b1;
      counter_array_pkg::SEL_EXT_DIV: next_tick = ext_clk_in && !ext_clk_q
                                                  && (ext_count == 3'(`DIV_EXT - 1));
      default:                        next_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= next_tick;
    end
  end

endmodule

`default_nettype wire

// ===== verilog/counter_array_watchdog_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "counter_array_defines.svh"

module counter_array_watchdog_control #(
  parameter int MODULES = 5                           // Capture/compare modules
) (
  input  wire logic               clk_sys_in,         // System clock, 100 MHz
  input  wire logic               reset_in,           // Synchronous reset, high
  input  wire logic [7:0]         sfr_addr_in,        // Byte register address
  input  wire logic               sfr_write_in,       // Byte write strobe
  input  wire logic               sfr_read_in,        // Byte read strobe
  input  wire logic [7:0]         sfr_wdata_in,       // Byte write data
  input  wire logic [7:0]         bit_addr_in,        // Bit address
  input  wire logic               bit_write_in,       // Bit write strobe
  input  wire logic               bit_value_in,       // Bit write value
  input  wire logic [MODULES-1:0] module_event_in,    // Module match/capture pulses
  input  wire logic [MODULES-1:0] module_int_en_in,   // Module interrupt enables
  input  wire logic               cpu_idle_in,        // Processor in idle mode
  input  wire logic               timer0_ovf_in,      // Timer 0 overflow pulse
  input  wire logic               ext_pin_in,         // External count pin
  input  wire logic               ext_clk_in,         // External clock input
  output logic [7:0]              sfr_rdata_out,      // Read data, one cycle late
  output logic                    interrupt_out,      // Shared interrupt request
  output logic                    watchdog_reset_out, // Watchdog reset pulse
  output logic [15:0]             count_out           // Counter value
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic               run_bit;
  logic               idle_suspend_bit;
  logic               watchdog_enable_bit;
  logic               watchdog_lock_bit;
  logic [2:0]         counter_clock_select;
  logic               wrap_interrupt_enable;
  logic [7:0]         counter_low_byte;
  logic [7:0]         counter_high_byte;
  logic [7:0]         watchdog_offset_register;
  logic [7:0]         watchdog_update_register;
  logic               counter_wrap_flag;
  logic [MODULES-1:0] module_event_flag;

  logic               tick;
  logic               count_enable;
  logic               low_overflow;
  logic               wrap_event;
  logic               wr_ctl_byte;
  logic               wr_ctl_any;
  logic [7:0]         ctl_wmask;
  logic [7:0]         ctl_wdata;
  logic               wr_mode;
  logic               wr_low;
  logic               wr_high;
  logic               wr_offset;
  logic               wr_update;
  logic               force_reset;
  logic               next_wd_reset;
  logic [7:0]         control_read;
  logic [7:0]         mode_read;
  logic [7:0]         next_rdata;

  // ----------------------------------------
  // Decode of byte and bit writes
  // ----------------------------------------
  assign wr_ctl_byte = sfr_write_in && (sfr_addr_in == `ADDR_CONTROL);
  assign wr_mode     = sfr_write_in && (sfr_addr_in == `ADDR_MODE);
  assign wr_low      = sfr_write_in && (sfr_addr_in == `ADDR_COUNT_LOW);
  assign wr_high     = sfr_write_in && (sfr_addr_in == `ADDR_COUNT_HIGH);
  assign wr_offset   = sfr_write_in && (sfr_addr_in == `ADDR_WD_OFFSET);
  assign wr_update   = sfr_write_in && (sfr_addr_in == `ADDR_WD_UPDATE);

  // Bit writes touch one control bit and leave the others alone
  always_comb begin
    ctl_wmask = 8'h00;
    ctl_wdata = sfr_wdata_in;
    if (wr_ctl_byte) begin
      ctl_wmask = 8'hFF;
    end else if (bit_write_in && (bit_addr_in[7:3] == `BIT_BASE_CONTROL)) begin
      ctl_wmask[bit_addr_in[2:0]] = 1'b1;
      ctl_wdata = {8{bit_value_in}};
    end
  end

  assign wr_ctl_any = |ctl_wmask;

  // ----------------------------------------
  // Control register: run bit
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      run_bit <= 1'b0;
    end else if (ctl_wmask[`CTL_RUN]) begin
      run_bit <= ctl_wdata[`CTL_RUN];
    end
  end

  // ----------------------------------------
  // Mode register
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      watchdog_enable_bit <= 1'(`MODE_RESET >> `MODE_WD_EN);
      watchdog_lock_bit   <= 1'b0;
    end else if (wr_mode) begin
      if (sfr_wdata_in[`MODE_WD_EN] || sfr_wdata_in[`MODE_LOCK]) begin
        watchdog_enable_bit <= 1'b1;
      end else if (!watchdog_lock_bit) begin
        watchdog_enable_bit <= 1'b0;
      end
      // Lock only sets; it falls again at the next reset
      if (sfr_wdata_in[`MODE_LOCK]) begin
        watchdog_lock_bit <= 1'b1;
      end
    end
  end

  // Time base, idle and interrupt enable follow the same freeze
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      idle_suspend_bit      <= 1'b0;
      counter_clock_select  <= counter_array_pkg::SEL_DIV12;
      wrap_interrupt_enable <= 1'b0;
    end else if (wr_mode && !watchdog_enable_bit) begin
      idle_suspend_bit      <= sfr_wdata_in[`MODE_IDLE];
      counter_clock_select  <= sfr_wdata_in[`MODE_SEL_HI:`MODE_SEL_LO];
      wrap_interrupt_enable <= sfr_wdata_in[`MODE_WRAP_IE];
    end
  end

  // ----------------------------------------
  // Counter time base
  // ----------------------------------------
  counter_tick_gen u_tick (
    .clk_sys_in    (clk_sys_in),
    .reset_in      (reset_in),
    .select_in     (counter_clock_select),
    .timer0_ovf_in (timer0_ovf_in),
    .ext_pin_in    (ext_pin_in),
    .ext_clk_in    (ext_clk_in),
    .tick_out      (tick)
  );

  // Watchdog forces the counter on; idle suspend overrides both
  assign count_enable = (run_bit || watchdog_enable_bit)
                        && !(cpu_idle_in && idle_suspend_bit)
                        && tick;
  assign low_overflow = count_enable && (counter_low_byte == 8'hFF);
  assign wrap_event   = low_overflow && (counter_high_byte == 8'hFF);

  // ----------------------------------------
  // Counter bytes
  // ----------------------------------------
  // Software loads are locked out while the watchdog runs
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      counter_low_byte <= `BYTE_RESET;
    end else if (wr_low && !watchdog_enable_bit) begin
      counter_low_byte <= sfr_wdata_in;
    end else if (count_enable) begin
      counter_low_byte <= counter_low_byte + 8'h01;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      counter_high_byte <= `BYTE_RESET;
    end else if (wr_high && !watchdog_enable_bit) begin
      counter_high_byte <= sfr_wdata_in;
    end else if (low_overflow) begin
      counter_high_byte <= counter_high_byte + 8'h01;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      count_out <= `COUNT_RESET;
    end else begin
      count_out <= {counter_high_byte, counter_low_byte};
    end
  end

  // ----------------------------------------
  // Watchdog offset and update
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      watchdog_offset_register <= `BYTE_RESET;
    end else if (wr_offset) begin
      watchdog_offset_register <= sfr_wdata_in;
    end
  end

  // Written data is ignored: any write is a refresh
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      watchdog_update_register <= `BYTE_RESET;
    end else if (wr_update) begin
      watchdog_update_register <= counter_high_byte + watchdog_offset_register;
    end
  end

  // Writing one to module 4 flag while armed forces a reset
  assign force_reset = watchdog_enable_bit && ctl_wmask[`CTL_FLAG_HI]
                       && ctl_wdata[`CTL_FLAG_HI];

  // A refresh in the same cycle as the expiry loses to the expiry,
  // since the compare uses the value held before the write
  assign next_wd_reset = (watchdog_enable_bit && low_overflow
                          && (counter_high_byte == watchdog_update_register))
                         || force_reset;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      watchdog_reset_out <= 1'b0;
    end else begin
      watchdog_reset_out <= next_wd_reset;
    end
  end

  // ----------------------------------------
  // Sticky flags
  // ----------------------------------------
  sticky_flag u_wrap_flag (
    .clk_sys_in  (clk_sys_in),
    .reset_in    (reset_in),
    .hw_set_in   (wrap_event),
    .sw_write_in (ctl_wmask[`CTL_WRAP]),
    .sw_value_in (ctl_wdata[`CTL_WRAP]),
    .flag_out    (counter_wrap_flag)
  );

  genvar g;
  generate
    for (g = 0; g < MODULES; g = g + 1) begin : g_module_flag
      sticky_flag u_flag (
        .clk_sys_in  (clk_sys_in),
        .reset_in    (reset_in),
        .hw_set_in   (module_event_in[g]),
        .sw_write_in (ctl_wmask[g]),
        .sw_value_in (ctl_wdata[g]),
        .flag_out    (module_event_flag[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Shared interrupt request
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      interrupt_out <= 1'b0;
    end else begin
      interrupt_out <= (counter_wrap_flag && wrap_interrupt_enable)
                       || |(module_event_flag & module_int_en_in);
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    control_read                 = 8'h00;
    control_read[MODULES-1:0]    = module_event_flag;
    control_read[`CTL_RUN]       = run_bit;
    control_read[`CTL_WRAP]      = counter_wrap_flag;
  end

  always_comb begin
    mode_read                            = 8'h00;
    mode_read[`MODE_IDLE]                = idle_suspend_bit;
    mode_read[`MODE_WD_EN]               = watchdog_enable_bit;
    mode_read[`MODE_LOCK]                = watchdog_lock_bit;
    mode_read[`MODE_SEL_HI:`MODE_SEL_LO] = counter_clock_select;
    mode_read[`MODE_WRAP_IE]             = wrap_interrupt_enable;
  end

  always_comb begin
    case (sfr_addr_in)
      `ADDR_CONTROL:    next_rdata = control_read;
      `ADDR_MODE:       next_rdata = mode_read;
      `ADDR_COUNT_LOW:  next_rdata = counter_low_byte;
      `ADDR_COUNT_HIGH: next_rdata = counter_high_byte;
      `ADDR_WD_OFFSET:  next_rdata = watchdog_offset_register;
      `ADDR_WD_UPDATE:  next_rdata = watchdog_update_register;
      default:          next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (sfr_read_in) begin
      sfr_rdata_out <= next_rdata;
    end
  end

  // is a software sequence; wr_ctl_any marks any control write, the run bit included
  logic unused_ok;
  assign unused_ok = wr_ctl_any;

endmodule

`default_nettype wire

// ===== verif/counter_array_watchdog_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Port checker
// ----------------------------------------
module counter_array_watchdog_control_asserts #(
  parameter int MODULES = 5                        // Modules
) (
  input  wire logic               clk_sys_in,         // Clock
  input  wire logic               reset_in,           // Reset
  input  wire logic [7:0]         sfr_addr_in,        // Address
  input  wire logic               sfr_write_in,       // Byte write
  input  wire logic               sfr_read_in,        // Byte read
  input  wire logic               bit_write_in,       // Bit write
  input  wire logic [MODULES-1:0] module_event_in,    // Events
  input  wire logic [MODULES-1:0] module_int_en_in,   // Enables
  input  wire logic [7:0]         sfr_rdata_out,      // Read data
  input  wire logic               interrupt_out,      // Interrupt
  input  wire logic               watchdog_reset_out, // Reset pulse
  input  wire logic [15:0]        count_out           // Counter
);
  logic [12:0] cyc;
  logic        untouched;

  // Any write may legally force or delay expiry, so only untouched runs are timed
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) cyc <= 13'h0000;
    else if (cyc != 13'h1FFF) cyc <= cyc + 13'h0001;
  end
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) untouched <= 1'b1;
    else if (sfr_write_in || bit_write_in) untouched <= 1'b0;
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  property p_pulse; watchdog_reset_out |=> !watchdog_reset_out; endproperty
  property p_default; watchdog_reset_out && untouched |-> cyc >= 13'd3050 && cyc <= 13'd3090;
  endproperty
  property p_hold; !sfr_read_in |=> $stable(sfr_rdata_out); endproperty
  property p_ctl5; sfr_read_in && sfr_addr_in == 8'hD8 |=> !sfr_rdata_out[5]; endproperty
  property p_mode4; sfr_read_in && sfr_addr_in == 8'hD9 |=> !sfr_rdata_out[4]; endproperty
  property p_cnt_reset;
    $past(reset_in) |-> count_out == 16'h0000 && !interrupt_out && !watchdog_reset_out;
  endproperty
  property p_int; (module_event_in & module_int_en_in) != '0 |-> ##[1:2] interrupt_out;
  endproperty
  property p_step;
    $changed(count_out) && !$past(sfr_write_in) && !$past(sfr_write_in, 2)
      |-> count_out == $past(count_out) + 16'h0001;
  endproperty

  a_pulse: assert property (p_pulse) else $error("watchdog reset longer than one cycle");
  a_default: assert property (p_default) else $error("default expiry off time");
  a_hold: assert property (p_hold) else $error("read data changed without read");
  a_ctl5: assert property (p_ctl5) else $error("control bit 5 not zero");
  a_mode4: assert property (p_mode4) else $error("mode bit 4 not zero");
  a_cnt_reset: assert property (p_cnt_reset) else $error("outputs not cleared by reset");
  a_int: assert property (p_int) else $error("module interrupt missing");
  a_step: assert property (p_step) else $error("counter jumped");

  c_wd: cover property (watchdog_reset_out);
  c_int: cover property (interrupt_out);
  c_wrap: cover property (count_out == 16'h0000 && $past(count_out) == 16'hFFFF);
endmodule

bind counter_array_watchdog_control counter_array_watchdog_control_asserts #(
  .MODULES(MODULES)
) i_asserts (
  .clk_sys_in, .reset_in, .sfr_addr_in, .sfr_write_in, .sfr_read_in, .bit_write_in,
  .module_event_in, .module_int_en_in, .sfr_rdata_out, .interrupt_out,
  .watchdog_reset_out, .count_out
);

`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        clk_sys_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [7:0]  sfr_addr_in = 8'h00;
  logic        sfr_write_in = 1'b0;
  logic        sfr_read_in = 1'b0;
  logic [7:0]  sfr_wdata_in = 8'h00;
  logic [7:0]  bit_addr_in = 8'h00;
  logic        bit_write_in = 1'b0;
  logic        bit_value_in = 1'b0;
  logic [4:0]  module_event_in = 5'h00;
  logic [4:0]  module_int_en_in = 5'h00;
  logic        cpu_idle_in = 1'b0;
  logic [7:0]  sfr_rdata_out;
  logic        interrupt_out;
  logic        watchdog_reset_out;
  logic [15:0] count_out;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          n;

  counter_array_watchdog_control #(.MODULES(5)) i_dut (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .sfr_addr_in(sfr_addr_in),
    .sfr_write_in(sfr_write_in), .sfr_read_in(sfr_read_in), .sfr_wdata_in(sfr_wdata_in),
    .bit_addr_in(bit_addr_in), .bit_write_in(bit_write_in), .bit_value_in(bit_value_in),
    .module_event_in(module_event_in), .module_int_en_in(module_int_en_in),
    .cpu_idle_in(cpu_idle_in), .timer0_ovf_in(1'b0), .ext_pin_in(1'b0), .ext_clk_in(1'b0),
    .sfr_rdata_out(sfr_rdata_out), .interrupt_out(interrupt_out),
    .watchdog_reset_out(watchdog_reset_out), .count_out(count_out)
  );

  always #5 clk_sys_in = ~clk_sys_in;

  // ----------------------------------------
  // Bus tasks and reporting
  // ----------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("mismatch at %0t: run hung", $time);
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_write_in = 1'b1;
    @(negedge clk_sys_in);
    sfr_write_in = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys_in);
    sfr_addr_in = a;
    sfr_read_in = 1'b1;
    @(negedge clk_sys_in);
    sfr_read_in = 1'b0;
    chk({8'h00, sfr_rdata_out}, {8'h00, exp}, "register read");
  endtask

  task automatic bitw(input logic [7:0] a, input logic v);
    @(negedge clk_sys_in);
    bit_addr_in = a;
    bit_value_in = v;
    bit_write_in = 1'b1;
    @(negedge clk_sys_in);
    bit_write_in = 1'b0;
  endtask

  task automatic do_reset();
    @(negedge clk_sys_in);
    reset_in = 1'b1;
    repeat (12) @(negedge clk_sys_in);
    reset_in = 1'b0;
  endtask

  // Counts cycles to the next watchdog pulse, bounded
  task automatic wait_wd(input int lo, input int hi);
    n = 0;
    while (watchdog_reset_out !== 1'b1 && n < 4000) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk({15'h0000, n >= lo && n <= hi}, 16'h0001, "watchdog expiry time");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    do_reset();
    rd(8'hD9, 8'h40);
    rd(8'hD8, 8'h00);
    rd(8'hF9, 8'h00);
    rd(8'hFB, 8'h00);
    rd(8'h00, 8'h00);
    wait_wd(3040, 3090);
  endtask

  task automatic t_lock();
    do_reset();
    wr(8'hD9, 8'h00);
    rd(8'hD9, 8'h00);
    wr(8'hD9, 8'h89);
    rd(8'hD9, 8'h89);
    wr(8'hD9, 8'hA9);
    rd(8'hD9, 8'hE9);
    // Idle-suspend is set, so idle must pause even the forced-on counter
    cpu_idle_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    n = count_out;
    repeat (5) @(negedge clk_sys_in);
    chk(count_out, 16'(n), "idle suspended counter");
    cpu_idle_in = 1'b0;
    wr(8'hD9, 8'h00);
    rd(8'hD9, 8'hE9);
  endtask

  task automatic t_refresh();
    do_reset();
    wr(8'hD9, 8'h00);
    wr(8'hD9, 8'h08);
    wr(8'hFA, 8'h10);
    wr(8'hFB, 8'h05);
    wr(8'hD9, 8'h48);
    // Refresh comes last, after the enable, as software must do it
    wr(8'hFC, 8'hAA);
    rd(8'hFC, 8'h15);
    // Ignored while enabled, otherwise expiry moves by thousands of cycles
    wr(8'hFA, 8'h00);
    wait_wd(1528, 1545);
  endtask

  task automatic t_flags();
    do_reset();
    wr(8'hD9, 8'h00);
    wr(8'hD9, 8'h09);
    wr(8'hF9, 8'hFE);
    wr(8'hFA, 8'hFF);
    repeat (5) @(negedge clk_sys_in);
    chk(count_out, 16'hFFFE, "stopped counter");
    bitw(8'hDE, 1'b1);
    repeat (4) @(negedge clk_sys_in);
    bitw(8'hDE, 1'b0);
    rd(8'hD8, 8'h80);
    chk({15'h0000, interrupt_out}, 16'h0001, "wrap interrupt");
    repeat (20) @(negedge clk_sys_in);
    rd(8'hD8, 8'h80);
    wr(8'hD8, 8'h20);
    rd(8'hD8, 8'h00);
    @(negedge clk_sys_in);
    module_int_en_in = 5'h04;
    module_event_in = 5'h1F;
    @(negedge clk_sys_in);
    module_event_in = 5'h00;
    repeat (2) @(negedge clk_sys_in);
    chk({15'h0000, interrupt_out}, 16'h0001, "module interrupt");
    module_int_en_in = 5'h00;
    repeat (2) @(negedge clk_sys_in);
    chk({15'h0000, interrupt_out}, 16'h0000, "masked interrupt");
    rd(8'hD8, 8'h1F);
    bitw(8'hDA, 1'b0);
    rd(8'hD8, 8'h1B);
    // Settle first: the shared prescaler may sit beyond the /4 wrap point
    wr(8'hD9, 8'h02);
    bitw(8'hDE, 1'b1);
    repeat (20) @(negedge clk_sys_in);
    n = count_out;
    repeat (40) @(negedge clk_sys_in);
    chk(count_out, 16'(n + 10), "divide-by-4 time base");
  endtask

  initial begin
    t_reset_values();
    t_lock();
    t_refresh();
    t_flags();
    end_sim();
  end
endmodule

`default_nettype wire
